/* File: logic/interrupt_aggregator.sv */
/*
 * interrupt aggregator: latches six sub-module conditions into
 * write-one-to-clear flags, gates them by a mask, drives int_n low.
 * assumes condition inputs are synchronous one-cycle pulses and the
 * configuration port gives single-cycle write and read strobes.
 */
`timescale 1ns/1ps
module interrupt_aggregator
    import int_agg_pkg::*;
#(
    parameter int JIT_WIDTH = 8
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_rd,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    input  wire logic       mode_bit_toggle,
    input  wire logic       mode_value_change,
    input  wire logic       mode_sync_jitter,
    input  wire logic       auto_adjust_done,
    input  wire logic       fifo_full,
    input  wire logic       osd_sequence_end,
    input  wire logic       oif_stream_break,
    input  wire logic       line_jitter_event,
    output logic            int_n
);
    logic [NUM_FLAGS-1:0] flags_reg;
    logic [NUM_FLAGS-1:0] flags_next;
    logic [7:0]           mask_reg;
    logic [7:0]           mask_next;
    logic [7:0]           thresh_reg;
    logic [7:0]           thresh_next;
    logic [7:0]           rdata_next;
    logic                 int_n_next;
    logic                 fifo_full_reg;
    logic                 jitter_exceeded;
    logic [NUM_FLAGS-1:0] events;
    logic [NUM_FLAGS-1:0] clear_bits;

    // register address match used by several decoders
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // hysteresis-free threshold counter for line jitter
    jitter_counter #(
        .WIDTH        (JIT_WIDTH)
    ) u_jitter (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .clk_en       (clk_en),
        .restart      (~mask_reg[BIT_IIF]),
        .jitter_event (line_jitter_event),
        .threshold    (thresh_reg[JIT_WIDTH-1:0]),
        .exceeded     (jitter_exceeded)
    );

    // raw events, fifo taken on its rising edge
    always_comb begin
        events           = '0;
        events[BIT_MODE] = mode_bit_toggle | mode_value_change | mode_sync_jitter;
        events[BIT_AUTO] = auto_adjust_done;
        events[BIT_FIFO] = fifo_full & ~fifo_full_reg;
        events[BIT_OSD]  = osd_sequence_end;
        events[BIT_OIF]  = oif_stream_break;
        events[BIT_IIF]  = jitter_exceeded;
    end

    // write-one clear of the status register
    always_comb begin
        clear_bits = '0;
        if (cfg_wr && hit(cfg_addr, ADDR_STATUS)) begin
            clear_bits = cfg_wdata[NUM_FLAGS-1:0];
        end
    end

    // flag, mask and threshold next values
    always_comb begin
        mask_next   = mask_reg;
        thresh_next = thresh_reg;
        if (cfg_wr && hit(cfg_addr, ADDR_MASK)) begin
            mask_next = cfg_wdata;
        end
        if (cfg_wr && hit(cfg_addr, ADDR_JIT_THRESH)) begin
            thresh_next = cfg_wdata;
        end
        // set wins over clear; masked events ignored
        flags_next = (flags_reg & ~clear_bits)
                   | (events & mask_reg[NUM_FLAGS-1:0]);
        int_n_next = ~|(flags_next & mask_reg[NUM_FLAGS-1:0]);
    end

    // read data
    always_comb begin
        rdata_next = cfg_rdata;
        if (cfg_rd) begin
            case (1'b1)
                hit(cfg_addr, ADDR_STATUS):     rdata_next = {2'b00, flags_reg};
                hit(cfg_addr, ADDR_MASK):       rdata_next = mask_reg;
                hit(cfg_addr, ADDR_JIT_THRESH): rdata_next = thresh_reg;
                default:                        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg     <= '0;
            mask_reg      <= MASK_RESET;
            thresh_reg    <= JIT_THRESH_RESET;
            fifo_full_reg <= 1'b0;
            cfg_rdata     <= 8'h00;
            int_n         <= 1'b1;
        end else if (clk_en) begin
            flags_reg     <= flags_next;
            mask_reg      <= mask_next;
            thresh_reg    <= thresh_next;
            fifo_full_reg <= fifo_full;
            cfg_rdata     <= rdata_next;
            int_n         <= int_n_next;
        end
    end
endmodule

/* File: logic/int_agg_pkg.sv */
/*
 * constants and register map of the interrupt aggregator.
 * assumes a configuration-register port that delivers byte-wide
 * reads and writes addressed by an 8-bit register address.
 */
package int_agg_pkg;
    localparam int          NUM_FLAGS          = 6;
    localparam logic [7:0]  ADDR_MASK          = 8'hfd;
    localparam logic [7:0]  ADDR_STATUS        = 8'hfe;
    localparam logic [7:0]  ADDR_JIT_THRESH    = 8'hfc;
    localparam logic [7:0]  MASK_RESET         = 8'h00;
    localparam logic [7:0]  JIT_THRESH_RESET   = 8'h00;
    // flag bit positions
    localparam int          BIT_MODE           = 0;
    localparam int          BIT_AUTO           = 1;
    localparam int          BIT_FIFO           = 2;
    localparam int          BIT_OSD            = 3;
    localparam int          BIT_OIF            = 4;
    localparam int          BIT_IIF            = 5;
endpackage

/* File: logic/jitter_counter.sv */
/*
 * counts line-jitter events and fires one pulse when the count
 * passes the threshold. assumes jitter_event is a one-cycle pulse
 * synchronous to clock.
 */
`timescale 1ns/1ps
module jitter_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             restart,
    input  wire logic             jitter_event,
    input  wire logic [WIDTH-1:0] threshold,
    output logic                  exceeded
);
    logic [WIDTH:0] count_reg;
    logic [WIDTH:0] count_next;
    logic           exceeded_next;

    // count events, restart after threshold passed or on request
    always_comb begin
        count_next    = count_reg;
        exceeded_next = 1'b0;
        if (restart) begin
            count_next = '0;
        end else if (jitter_event) begin
            if (count_reg >= {1'b0, threshold}) begin
                exceeded_next = 1'b1;
                count_next    = '0;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
            exceeded  <= 1'b0;
        end else if (clk_en) begin
            count_reg <= count_next;
            exceeded  <= exceeded_next;
        end
    end
endmodule

/* File: tb/int_agg_props.sv */
/* assertions on the interrupt aggregator ports.
   assumes one clock domain and an active-high async reset. */
`timescale 1ns/1ps
module int_agg_checker
    import int_agg_pkg::*;
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       clk_en,
    input wire logic [7:0] cfg_addr,
    input wire logic       cfg_wr,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic       mode_bit_toggle,
    input wire logic       auto_adjust_done,
    input wire logic       osd_sequence_end,
    input wire logic       oif_stream_break,
    input wire logic       int_n
);
    logic [7:0] msk_reg;
    logic [7:0] msk_next;
    // shadow of the enable mask
    always_comb begin
        msk_next = (clk_en && cfg_wr && cfg_addr == ADDR_MASK) ? cfg_wdata : msk_reg;
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            msk_reg <= MASK_RESET;
        end else begin
            msk_reg <= msk_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence rd_s(a); clk_en && cfg_rd && cfg_addr == a; endsequence
    sequence quiet_s; (msk_reg[5:0] == 6'h00) [*2]; endsequence
    mode_set_a: assert property (clk_en && mode_bit_toggle && msk_reg[0] |=> !int_n)
        else $error("mode event left int_n high");
    auto_set_a: assert property (clk_en && auto_adjust_done && msk_reg[1] |=> !int_n)
        else $error("auto event left int_n high");
    osd_set_a: assert property (clk_en && osd_sequence_end && msk_reg[3] |=> !int_n)
        else $error("osd event left int_n high");
    oif_set_a: assert property (clk_en && oif_stream_break && msk_reg[4] |=> !int_n)
        else $error("oif event left int_n high");
    masked_quiet_a: assert property (quiet_s |-> int_n)
        else $error("int_n low with all masked");
    mask_read_a: assert property (rd_s(ADDR_MASK) |=> cfg_rdata == $past(msk_reg))
        else $error("mask readback wrong");
    status_top_a: assert property (rd_s(ADDR_STATUS) |=> cfg_rdata[7:6] == 2'h0)
        else $error("status bits 7:6 not zero");
    unmapped_rd_a: assert property (rd_s(8'h00) |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind interrupt_aggregator int_agg_checker int_agg_checker_inst (.*);

/* File: tb/mcu_model.sv */
/* receiving controller: counts falling edges of int_n.
   assumes int_n is registered on clock. */
`timescale 1ns/1ps
module mcu_model (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       int_n,
    output logic     [7:0] irq_count
);
    logic last_reg;
    // count each new interrupt request
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_reg  <= 1'b1;
            irq_count <= 8'h00;
        end else begin
            last_reg  <= int_n;
            irq_count <= irq_count + {7'h0, last_reg && !int_n};
        end
    end
endmodule

/* File: tb/test_interrupt_aggregator.sv */
/* self-checking bench for the interrupt aggregator.
   assumes the package, the design and the checker are compiled first. */
`timescale 1ns/1ps
module test_interrupt_aggregator;
    import int_agg_pkg::*;
    logic clock = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0;
    logic [7:0] cfg_addr = 0, cfg_wdata = 0, ev = 0, rdata, irq_count, got;
    logic int_n;
    int miscompares = 0, samples_checked = 0, t;
    always #5 clock = ~clock;
    interrupt_aggregator interrupt_aggregator_inst (.clock(clock), .sys_rst(sys_rst),
        .clk_en(1'b1), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(rdata), .mode_bit_toggle(ev[0]),
        .mode_value_change(ev[6]), .mode_sync_jitter(ev[7]), .auto_adjust_done(ev[1]),
        .fifo_full(ev[2]), .osd_sequence_end(ev[3]), .oif_stream_break(ev[4]),
        .line_jitter_event(ev[5]), .int_n(int_n));
    mcu_model mcu_model_inst (.clock(clock), .sys_rst(sys_rst), .int_n(int_n),
        .irq_count(irq_count));
    // write cycle, optionally with condition pulses in the same cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clock); #1 cfg_addr = a; cfg_wdata = d; cfg_wr = 1; ev = e;
        @(posedge clock); #1 cfg_wr = 0; ev = 0;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] x);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clock); #1 cfg_addr = a; cfg_rd = 1;
        @(posedge clock); #1 cfg_rd = 0;
        cmp(rdata, x);
    endtask
    function automatic logic [7:0] bit_of(input int b);
        return 8'h01 << b;
    endfunction
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000 miscompares++;
        summarize();
    end
    initial begin
        t = $urandom(62272);
        t = $urandom % 4;
        repeat (4) @(posedge clock);
        #1 sys_rst = 0;
        rd(ADDR_MASK, MASK_RESET);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_MASK, 8'h3f, 0);
        rd(ADDR_MASK, 8'h3f);
        for (int b = 0; b < 5; b++) begin
            wr(8'h00, 8'hff, bit_of(b));
            cmp({7'h0, int_n}, 8'h00);
            wr(ADDR_STATUS, 8'h00, 0);
            rd(ADDR_STATUS, bit_of(b));
            wr(ADDR_STATUS, bit_of(b), 0);
            cmp({7'h0, int_n}, 8'h01);
            rd(8'h00, 8'h00);
        end
        for (int b = 6; b < 8; b++) begin
            wr(8'h00, 8'h00, bit_of(b));
            rd(ADDR_STATUS, 8'h01);
            wr(ADDR_STATUS, 8'h01, 0);
        end
        wr(ADDR_MASK, 8'h00, 0);
        wr(8'h00, 8'h00, 8'h1f);
        rd(ADDR_STATUS, 8'h00);
        cmp({7'h0, int_n}, 8'h01);
        wr(ADDR_MASK, 8'h3f, 0);
        wr(ADDR_STATUS, 8'h02, 8'h02);
        rd(ADDR_STATUS, 8'h02);
        wr(ADDR_STATUS, 8'h02, 0);
        wr(ADDR_JIT_THRESH, t[7:0], 0);
        repeat (t) wr(8'h00, 8'h00, 8'h20);
        rd(ADDR_STATUS, 8'h00);
        wr(8'h00, 8'h00, 8'h20);
        rd(ADDR_STATUS, 8'h20);
        cmp(irq_count, 8'h09);
        summarize();
    end
endmodule
